// [src/bpm_regs.svh]
`ifndef BPM_REGS_SVH
`define BPM_REGS_SVH
// Summary of operation
// - Almost-full low at fill of depth minus X or more, high otherwise
// - Offset X loaded after reset from offset selects: 16, 12, 8 or 4
// - Almost-full released on second writing port edge after the read
// - Edges too close to the read slip one synchronizer cycle
// - Port A mail write stores port A bus into A-to-B mailbox
// - Port B write with both size selects high stores bus into B-to-A mailbox
// - Mailbox write drives its flag low; writes ignored while flag low
// - Port A drives queue output register, or B-to-A mailbox when mail selected
// - Port B drives queue output register, or A-to-B mailbox with both sizes high
// - Mailbox read sets that mailbox flag high on reading port edge
// - Mailbox read keeps contents; only accepted writes change them
// - Port B long, word and byte widths, big or little endian lanes
// - Size and endian selects registered each port B edge without mailbox select, applied next edge
// - Queues move whole long words; width matching skips mailboxes
// - Narrow reads show pieces in order from held long word
// - Read with changed width unloads fresh long word, dropping unread pieces
// - Unused port B output lanes during narrow reads carry no meaning
// - Narrow writes collect pieces; last piece commits whole long word
// - Write with changed width restarts assembly, losing uncommitted pieces
// - Port B mailbox access is immediate and keeps prior width selection
// - Four byte orders for queue data at any width, never for mailboxes
// - Swap codes: keep, reverse bytes, exchange halves, swap bytes within halves
// - Swap mode sampled at first piece and kept for whole long word
// - Reads swap then split; writes assemble then swap at commit

// Register offsets
`define BPM_OFF_STATUS 32'h0000_0000
`define BPM_OFF_CTRL 32'h0000_0004
`define BPM_OFF_MB_AB 32'h0000_0008
`define BPM_OFF_MB_BA 32'h0000_000C
// Control bit: write one frees both mailboxes
`define BPM_CTRL_MAIL_FREE 0
// Status fields
`define BPM_ST_OFFSET_LSB 0
`define BPM_ST_MB_AB_N 8
`define BPM_ST_MB_BA_N 9
`define BPM_ST_AF_A_N 10
`define BPM_ST_AF_B_N 11
`define BPM_ST_SIZE_LSB 12
`define BPM_ST_LE 14
// Reset values
`define BPM_FLAG_RESET 1'b1
`define BPM_QUEUE_DEPTH 64
// Offset presets
`define BPM_OFFSET_HH 7'h10
`define BPM_OFFSET_HL 7'h0C
`define BPM_OFFSET_LH 7'h08
`define BPM_OFFSET_LL 7'h04
// Synchroniser depth in clock cycles
`define BPM_SYNC_STAGES 2
// AXI responses
`define BPM_RESP_OKAY 2'b00
`define BPM_RESP_SLVERR 2'b10
`endif

// [src/bpm_pkg.sv]
package bpm_pkg;
  // Port B width codes, high select bit first
  typedef enum logic [1:0] {
    BPM_LONG = 2'b00,
    BPM_BYTE = 2'b01,
    BPM_WORD = 2'b10,
    BPM_MAIL = 2'b11
  } bpm_width_e;

  // Byte order modes
  typedef enum logic [1:0] {
    BPM_SW_NONE = 2'b00,
    BPM_SW_REV = 2'b01,
    BPM_SW_HALF = 2'b10,
    BPM_SW_INNER = 2'b11
  } bpm_swap_e;

  // Port A pins besides its clock
  typedef struct packed {
    logic port_a_select_n;
    logic port_a_direction;
    logic port_a_strobe;
    logic port_a_mail_select;
    logic [35:0] data;
  } bpm_pa_s;

  // Port B pins besides its clock
  typedef struct packed {
    logic port_b_select_n;
    logic port_b_direction;
    logic port_b_strobe;
    bpm_width_e width_select;
    logic big_endian_select_n;
    bpm_swap_e swap_select;
    logic [35:0] data;
  } bpm_pb_s;

  // Whole state of the port logic
  typedef struct packed {
    logic run;
    logic [6:0] offset;
    logic afa_s1;
    logic afa_n;
    logic afb_s1;
    logic afb_n;
    logic [35:0] mb_ab;
    logic mb_ab_n;
    logic [35:0] mb_ba;
    logic mb_ba_n;
    logic [35:0] a_qreg;
    logic [35:0] a_dout;
    logic a_oe;
    logic a_push;
    logic [35:0] a_wdata;
    logic a_pop;
    bpm_width_e b_size;
    logic b_le;
    logic [35:0] rd_buf;
    logic [1:0] rd_left;
    bpm_width_e rd_size;
    logic [35:0] b_qreg;
    logic [35:0] b_dout;
    logic b_oe;
    logic b_pop;
    logic [35:0] wr_buf;
    logic [1:0] wr_cnt;
    bpm_width_e wr_size;
    bpm_swap_e wr_sw;
    logic b_push;
    logic [35:0] b_wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } bpm_state_s;
endpackage : bpm_pkg

// [src/bpm_sync.sv]
module bpm_sync
  import bpm_pkg::*;
#(
  parameter int W = 1,
  parameter int STAGES = 2
)
(
  input wire logic aclk,        // System clock
  input wire logic aresetn,     // Synchronous reset, active low
  input wire logic [W-1:0] raw, // Foreign signals, bit 0 may be a clock
  output logic [W-1:0] sync,    // Synchronised copy
  output logic rise             // Pulse on rising edge of bit 0
);
  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  if (STAGES < 2)
  begin : g_bad_stages
    $error("too few stages");
  end

  typedef struct packed {
    logic [STAGES-1:0][W-1:0] chain;
    logic last;
  } bpm_sync_s;

  bpm_sync_s s_q;
  bpm_sync_s s_d;

  // --------------------------------------------------------------
  // Chain
  // --------------------------------------------------------------
  // Shift chain; only the final stage is looked at
  always_comb
  begin
    s_d = s_q;
    s_d.chain = {s_q.chain[STAGES-2:0], raw};
    s_d.last = s_q.chain[STAGES-1][0];
  end

  // Chain runs through reset
  always_ff @(posedge aclk)
  begin
    s_q.chain <= s_d.chain;
    s_q.last <= aresetn ? s_d.last : 1'b1;
  end

  // Outputs from the final stage
  assign sync = s_q.chain[STAGES-1];
  assign rise = s_q.chain[STAGES-1][0] & ~s_q.last;
endmodule : bpm_sync

// [src/bpm_port_logic.sv]
`include "bpm_regs.svh"

module bpm_port_logic
  import bpm_pkg::*;
#(
  parameter int DEPTH = `BPM_QUEUE_DEPTH
)
(
  input wire logic aclk,                    // System clock, 250 MHz
  input wire logic aresetn,                 // Synchronous reset, active low
  input wire logic [31:0] s_axi_awaddr,     // Write address
  input wire logic [2:0] s_axi_awprot,      // Write protection, unused
  input wire logic s_axi_awvalid,           // Write address valid
  output logic s_axi_awready,               // Write address ready
  input wire logic [31:0] s_axi_wdata,      // Write data
  input wire logic [3:0] s_axi_wstrb,       // Write strobes
  input wire logic s_axi_wvalid,            // Write data valid
  output logic s_axi_wready,                // Write data ready
  output logic [1:0] s_axi_bresp,           // Write response
  output logic s_axi_bvalid,                // Write response valid
  input wire logic s_axi_bready,            // Write response ready
  input wire logic [31:0] s_axi_araddr,     // Read address
  input wire logic [2:0] s_axi_arprot,      // Read protection, unused
  input wire logic s_axi_arvalid,           // Read address valid
  output logic s_axi_arready,               // Read address ready
  output logic [31:0] s_axi_rdata,          // Read data
  output logic [1:0] s_axi_rresp,           // Read response
  output logic s_axi_rvalid,                // Read data valid
  input wire logic s_axi_rready,            // Read data ready
  input wire logic offset_select_low_bit,   // Offset preset, low bit
  input wire logic offset_select_high_bit,  // Offset preset, high bit
  input wire logic port_a_clock,            // Port A clock pin
  input wire bpm_pa_s port_a_pins,          // Port A controls and input bus
  output logic [35:0] port_a_dout,          // Port A output bus
  output logic port_a_oe,                   // Port A drives its bus
  output logic port_a_almost_full_n,        // A-to-B queue almost full
  input wire logic port_b_clock,            // Port B clock pin
  input wire bpm_pb_s port_b_pins,          // Port B controls and input bus
  output logic [35:0] port_b_dout,          // Port B output bus
  output logic port_b_oe,                   // Port B drives its bus
  output logic port_b_almost_full_n,        // B-to-A queue almost full
  output logic mailbox_a_to_b_flag_n,       // A-to-B mailbox holds mail
  output logic mailbox_b_to_a_flag_n,       // B-to-A mailbox holds mail
  input wire logic [6:0] queue_a_to_b_fill, // A-to-B queue word count
  input wire logic [35:0] queue_a_to_b_head,// A-to-B queue head word
  output logic queue_a_to_b_push,           // Write pulse into A-to-B queue
  output logic [35:0] queue_a_to_b_wdata,   // Word for A-to-B queue
  output logic queue_a_to_b_pop,            // Take A-to-B head
  input wire logic [6:0] queue_b_to_a_fill, // B-to-A queue word count
  input wire logic [35:0] queue_b_to_a_head,// B-to-A queue head word
  output logic queue_b_to_a_push,           // Write pulse into B-to-A queue
  output logic [35:0] queue_b_to_a_wdata,   // Word for B-to-A queue
  output logic queue_b_to_a_pop             // Take B-to-A head
);
  // --------------------------------------------------------------
  // Checks and constants
  // --------------------------------------------------------------
  if (DEPTH < 17 || DEPTH > 127)
  begin : g_bad_depth
    $error("depth out of range");
  end

  localparam logic [6:0] DEPTH7 = 7'(DEPTH);

  // --------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------
  // Offset preset from the two select pins
  function automatic logic [6:0] offset_decode(input logic [1:0] sel);
    case (sel)
      2'b11: offset_decode = `BPM_OFFSET_HH;
      2'b10: offset_decode = `BPM_OFFSET_HL;
      2'b01: offset_decode = `BPM_OFFSET_LH;
      default: offset_decode = `BPM_OFFSET_LL;
    endcase
  endfunction : offset_decode

  // Fill at or above depth minus offset
  function automatic logic af_raw(input logic [6:0] fill, input logic [6:0] off);
    af_raw = fill >= (DEPTH7 - off);
  endfunction : af_raw

  // Byte order rearrangement, bits inside a byte kept
  function automatic logic [35:0] swap(input logic [35:0] w, input bpm_swap_e m);
    case (m)
      BPM_SW_REV: swap = {w[8:0], w[17:9], w[26:18], w[35:27]};
      BPM_SW_HALF: swap = {w[17:0], w[35:18]};
      BPM_SW_INNER: swap = {w[26:18], w[35:27], w[8:0], w[17:9]};
      default: swap = w;
    endcase
  endfunction : swap

  // Index of last piece for a width
  function automatic logic [1:0] last_idx(input bpm_width_e sz);
    case (sz)
      BPM_WORD: last_idx = 2'h1;
      BPM_BYTE: last_idx = 2'h3;
      default: last_idx = 2'h0;
    endcase
  endfunction : last_idx

  // Piece on active lanes, copied to idle ones
  function automatic logic [35:0] lane_out(input logic [35:0] w, input bpm_width_e sz,
                                           input logic le);
    case (sz)
      BPM_WORD: lane_out = le ? {2{w[17:0]}} : {2{w[35:18]}};
      BPM_BYTE: lane_out = le ? {4{w[8:0]}} : {4{w[35:27]}};
      default: lane_out = w;
    endcase
  endfunction : lane_out

  // Drop shown piece, next one moves in place
  function automatic logic [35:0] lane_shift(input logic [35:0] w, input bpm_width_e sz,
                                             input logic le);
    case (sz)
      BPM_WORD: lane_shift = le ? {18'h0_0000, w[35:18]} : {w[17:0], 18'h0_0000};
      BPM_BYTE: lane_shift = le ? {9'h000, w[35:9]} : {w[26:0], 9'h000};
      default: lane_shift = w;
    endcase
  endfunction : lane_shift

  // Fold one incoming piece into the assembly word
  function automatic logic [35:0] lane_insert(input logic [35:0] acc, input logic [35:0] bus,
                                              input bpm_width_e sz, input logic le);
    case (sz)
      BPM_WORD: lane_insert = le ? {bus[17:0], acc[35:18]} : {acc[17:0], bus[35:18]};
      BPM_BYTE: lane_insert = le ? {bus[8:0], acc[35:9]} : {acc[26:0], bus[35:27]};
      default: lane_insert = bus;
    endcase
  endfunction : lane_insert

  // --------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------
  logic [40:0] a_sync;
  logic [44:0] b_sync;
  logic [1:0] off_sync;
  logic pa_rise;
  logic pb_rise;
  bpm_pa_s pa;
  bpm_pb_s pb;

  // Edges landing close to a read slip one cycle here
  bpm_sync #(.W(41), .STAGES(`BPM_SYNC_STAGES)) u_sync_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw({port_a_pins, port_a_clock}),
    .sync(a_sync),
    .rise(pa_rise)
  );

  bpm_sync #(.W(45), .STAGES(`BPM_SYNC_STAGES)) u_sync_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw({port_b_pins, port_b_clock}),
    .sync(b_sync),
    .rise(pb_rise)
  );

  bpm_sync #(.W(2), .STAGES(`BPM_SYNC_STAGES)) u_sync_off (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw({offset_select_high_bit, offset_select_low_bit}),
    .sync(off_sync),
    .rise()
  );

  // Pin bundles as seen after synchronisation
  assign pa = a_sync[40:1];
  assign pb = b_sync[44:1];

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  bpm_state_s s_q;
  bpm_state_s s_d;

  always_comb
  begin
    logic ab_wr;
    logic ab_rd;
    logic ba_wr;
    logic ba_rd;
    logic mail_free;
    logic mail_b;
    logic [1:0] wcnt;
    logic [35:0] wbuf;
    logic [35:0] fresh;
    bpm_swap_e wsw;
    ab_wr = 1'b0;
    ab_rd = 1'b0;
    ba_wr = 1'b0;
    ba_rd = 1'b0;
    mail_free = 1'b0;
    mail_b = pb.width_select == BPM_MAIL;
    wcnt = 2'h0;
    wbuf = s_q.wr_buf;
    fresh = '0;
    wsw = s_q.wr_sw;
    s_d = s_q;
    s_d.a_push = 1'b0;
    s_d.a_pop = 1'b0;
    s_d.b_push = 1'b0;
    s_d.b_pop = 1'b0;

    // Offset loaded on first cycle after reset
    if (!s_q.run)
    begin
      s_d.run = 1'b1;
      s_d.offset = offset_decode(off_sync);
    end

    // Almost-full flags: set at once, released through two writer edges
    if (pa_rise)
    begin
      s_d.afa_s1 = af_raw(queue_a_to_b_fill, s_q.offset);
      s_d.afa_n = ~(af_raw(queue_a_to_b_fill, s_q.offset) | s_q.afa_s1);
    end
    if (pb_rise)
    begin
      s_d.afb_s1 = af_raw(queue_b_to_a_fill, s_q.offset);
      s_d.afb_n = ~(af_raw(queue_b_to_a_fill, s_q.offset) | s_q.afb_s1);
    end

    // Port A transfers
    if (pa_rise && !pa.port_a_select_n && pa.port_a_strobe)
    begin
      if (pa.port_a_direction)
      begin
        if (pa.port_a_mail_select)
          ab_wr = s_q.mb_ab_n;
        else if (queue_a_to_b_fill < DEPTH7)
        begin
          s_d.a_push = 1'b1;
          s_d.a_wdata = pa.data;
        end
      end
      else if (pa.port_a_mail_select)
        ba_rd = 1'b1;
      else if (queue_b_to_a_fill != 7'h00)
      begin
        s_d.a_pop = 1'b1;
        s_d.a_qreg = queue_b_to_a_head;
      end
    end

    // Port B transfers
    if (pb_rise)
    begin
      // Width latched each edge, held across mailbox access
      if (!mail_b)
      begin
        s_d.b_size = pb.width_select;
        s_d.b_le = pb.big_endian_select_n;
      end
      if (!pb.port_b_select_n && pb.port_b_strobe)
      begin
        if (mail_b)
        begin
          if (pb.port_b_direction)
            ba_wr = s_q.mb_ba_n;
          else
            ab_rd = 1'b1;
        end
        else if (!pb.port_b_direction)
        begin
          // Queue read: new long word when width changed or pieces used up
          if (s_q.b_size != s_q.rd_size || s_q.rd_left == 2'h0)
          begin
            if (queue_a_to_b_fill != 7'h00)
            begin
              fresh = swap(queue_a_to_b_head, pb.swap_select);
              s_d.b_pop = 1'b1;
              s_d.rd_size = s_q.b_size;
              s_d.rd_left = last_idx(s_q.b_size);
              s_d.b_qreg = lane_out(fresh, s_q.b_size, s_q.b_le);
              s_d.rd_buf = lane_shift(fresh, s_q.b_size, s_q.b_le);
            end
          end
          else
          begin
            s_d.rd_left = s_q.rd_left - 2'h1;
            s_d.b_qreg = lane_out(s_q.rd_buf, s_q.b_size, s_q.b_le);
            s_d.rd_buf = lane_shift(s_q.rd_buf, s_q.b_size, s_q.b_le);
          end
        end
        else
        begin
          // Queue write: assemble pieces, restart on width change
          wcnt = (s_q.b_size != s_q.wr_size) ? 2'h0 : s_q.wr_cnt;
          wbuf = lane_insert(s_q.wr_buf, pb.data, s_q.b_size, s_q.b_le);
          wsw = (wcnt == 2'h0) ? pb.swap_select : s_q.wr_sw;
          s_d.wr_size = s_q.b_size;
          s_d.wr_sw = wsw;
          s_d.wr_buf = wbuf;
          if (wcnt == last_idx(s_q.b_size))
          begin
            s_d.wr_cnt = 2'h0;
            if (queue_b_to_a_fill < DEPTH7)
            begin
              s_d.b_push = 1'b1;
              s_d.b_wdata = swap(wbuf, wsw);
            end
          end
          else
            s_d.wr_cnt = wcnt + 2'h1;
        end
      end
    end

    // Register writes
    if (s_axi_awvalid && s_axi_wvalid && !s_q.bvalid)
    begin
      s_d.bvalid = 1'b1;
      s_d.bresp = `BPM_RESP_OKAY;
      if (s_axi_awaddr == `BPM_OFF_CTRL)
        mail_free = s_axi_wstrb[0] & s_axi_wdata[`BPM_CTRL_MAIL_FREE];
      else if (s_axi_awaddr != `BPM_OFF_STATUS && s_axi_awaddr != `BPM_OFF_MB_AB &&
               s_axi_awaddr != `BPM_OFF_MB_BA)
        s_d.bresp = `BPM_RESP_SLVERR;
    end
    else if (s_q.bvalid && s_axi_bready)
      s_d.bvalid = 1'b0;

    // Register reads
    if (s_axi_arvalid && !s_q.rvalid)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `BPM_RESP_OKAY;
      s_d.rdata = 32'h0000_0000;
      if (s_axi_araddr == `BPM_OFF_STATUS)
      begin
        s_d.rdata[`BPM_ST_OFFSET_LSB +: 7] = s_q.offset;
        s_d.rdata[`BPM_ST_MB_AB_N] = s_q.mb_ab_n;
        s_d.rdata[`BPM_ST_MB_BA_N] = s_q.mb_ba_n;
        s_d.rdata[`BPM_ST_AF_A_N] = s_q.afa_n;
        s_d.rdata[`BPM_ST_AF_B_N] = s_q.afb_n;
        s_d.rdata[`BPM_ST_SIZE_LSB +: 2] = s_q.b_size;
        s_d.rdata[`BPM_ST_LE] = s_q.b_le;
      end
      else if (s_axi_araddr == `BPM_OFF_MB_AB)
        s_d.rdata = s_q.mb_ab[31:0];
      else if (s_axi_araddr == `BPM_OFF_MB_BA)
        s_d.rdata = s_q.mb_ba[31:0];
      else if (s_axi_araddr != `BPM_OFF_CTRL)
        s_d.rresp = `BPM_RESP_SLVERR;
    end
    else if (s_q.rvalid && s_axi_rready)
      s_d.rvalid = 1'b0;

    // Mailboxes: arriving mail beats a read or free
    if (ab_wr)
      s_d.mb_ab = pa.data;
    if (ba_wr)
      s_d.mb_ba = pb.data;
    s_d.mb_ab_n = ab_wr ? 1'b0 : ((ab_rd | mail_free) ? 1'b1 : s_q.mb_ab_n);
    s_d.mb_ba_n = ba_wr ? 1'b0 : ((ba_rd | mail_free) ? 1'b1 : s_q.mb_ba_n);

    // Output buses, mailbox data never swapped or sized
    s_d.a_oe = ~pa.port_a_select_n & ~pa.port_a_direction;
    s_d.a_dout = pa.port_a_mail_select ? s_q.mb_ba : s_q.a_qreg;
    s_d.b_oe = ~pb.port_b_select_n & ~pb.port_b_direction;
    s_d.b_dout = mail_b ? s_q.mb_ab : s_q.b_qreg;
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.afa_n <= `BPM_FLAG_RESET;
      s_q.afb_n <= `BPM_FLAG_RESET;
      s_q.mb_ab_n <= `BPM_FLAG_RESET;
      s_q.mb_ba_n <= `BPM_FLAG_RESET;
    end
    else
      s_q <= s_d;
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  // Bus handshakes
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_q.bvalid;
  assign s_axi_wready = s_axi_awvalid & s_axi_wvalid & ~s_q.bvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = ~s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;

  // Port pins and flags
  assign port_a_dout = s_q.a_dout;
  assign port_a_oe = s_q.a_oe;
  assign port_a_almost_full_n = s_q.afa_n;
  assign port_b_dout = s_q.b_dout;
  assign port_b_oe = s_q.b_oe;
  assign port_b_almost_full_n = s_q.afb_n;
  assign mailbox_a_to_b_flag_n = s_q.mb_ab_n;
  assign mailbox_b_to_a_flag_n = s_q.mb_ba_n;

  // Queue side strobes
  assign queue_a_to_b_push = s_q.a_push;
  assign queue_a_to_b_wdata = s_q.a_wdata;
  assign queue_a_to_b_pop = s_q.b_pop;
  assign queue_b_to_a_push = s_q.b_push;
  assign queue_b_to_a_wdata = s_q.b_wdata;
  assign queue_b_to_a_pop = s_q.a_pop;
endmodule : bpm_port_logic

// [sim/bpm_port_logic_assertions.sv]
module bpm_port_logic_assertions
  import bpm_pkg::*;
#(
  parameter int DEPTH = 64
)
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset
  input wire logic s_axi_awvalid, // In
  input wire logic s_axi_wvalid, // In
  input wire logic s_axi_awready, // Out
  input wire logic s_axi_bvalid, // Out
  input wire logic s_axi_arvalid, // In
  input wire logic s_axi_rvalid, // Out
  input wire bpm_pa_s port_a_pins, // In
  input wire bpm_pb_s port_b_pins, // In
  input wire logic port_a_oe, // Out
  input wire logic port_b_oe, // Out
  input wire logic port_a_almost_full_n, // Out
  input wire logic [6:0] queue_a_to_b_fill, // In
  input wire logic queue_b_to_a_push // Out
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_aw; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |-> s_axi_awready; endproperty
  property p_b; s_axi_awvalid && s_axi_awready |=> s_axi_bvalid; endproperty
  property p_r; s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid; endproperty
  property p_oa; port_a_pins.port_a_select_n [*5] |-> !port_a_oe; endproperty
  property p_ob; port_b_pins.port_b_select_n [*5] |-> !port_b_oe; endproperty
  property p_afr;
    $rose(port_a_almost_full_n) |-> $past(queue_a_to_b_fill) <= DEPTH - 5;
  endproperty
  property p_aff;
    $fell(port_a_almost_full_n) |-> $past(queue_a_to_b_fill) >= DEPTH - 16;
  endproperty
  property p_push; queue_b_to_a_push |=> !queue_b_to_a_push; endproperty
  a_aw: assert property (p_aw) else $error("write not taken");
  a_b: assert property (p_b) else $error("no write answer");
  a_r: assert property (p_r) else $error("no read answer");
  a_oa: assert property (p_oa) else $error("port a drives");
  a_ob: assert property (p_ob) else $error("port b drives");
  a_afr: assert property (p_afr) else $error("flag freed early");
  a_aff: assert property (p_aff) else $error("flag set early");
  a_push: assert property (p_push) else $error("long push");
endmodule : bpm_port_logic_assertions

bind bpm_port_logic bpm_port_logic_assertions #(.DEPTH(DEPTH)) u_chk (.*);

// [sim/bpm_queue_model.sv]
module bpm_queue_model
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset
  input wire logic push, // Store word
  input wire logic [35:0] wdata, // Word in
  input wire logic pop, // Take head
  output logic [6:0] fill, // Words held
  output logic [35:0] head // Head word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [35:0] q[$];
  logic [35:0] last = '0;
  // Updates on falling edge
  always @(negedge aclk)
  begin
    if (!aresetn) q.delete();
    if (pop && q.size() > 0) last = q.pop_front();
    if (push) q.push_back(wdata);
    fill = 7'(q.size());
    head = q.size() > 0 ? q[0] : ~last;
  end
endmodule : bpm_queue_model

// [sim/bidir_fifo_portb_match_mailbox_tb_top.sv]
module bidir_fifo_portb_match_mailbox_tb_top
  import bpm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, offset_select_low_bit = 0, offset_select_high_bit = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0;
  logic s_axi_rready = 1, port_a_clock = 0, port_b_clock = 0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic port_a_oe, port_b_oe, port_a_almost_full_n, port_b_almost_full_n;
  logic mailbox_a_to_b_flag_n, mailbox_b_to_a_flag_n;
  logic queue_a_to_b_push, queue_a_to_b_pop, queue_b_to_a_push, queue_b_to_a_pop;
  logic [6:0] queue_a_to_b_fill, queue_b_to_a_fill;
  logic [35:0] port_a_dout, port_b_dout, queue_a_to_b_head, queue_b_to_a_head, w, m;
  logic [35:0] queue_a_to_b_wdata, queue_b_to_a_wdata;
  logic [35:0] exp_q[$];
  bpm_pa_s port_a_pins = 40'h80_0000_0000;
  bpm_pb_s port_b_pins = 44'h800_0000_0000;
  int error_cnt = 0, checks = 0, cyc = 0, seed = 32'h0000_567c;
  always #2 aclk = ~aclk;
  bpm_port_logic #(.DEPTH(20)) DUT (.*);
  bpm_queue_model qab (.aclk, .aresetn, .push(queue_a_to_b_push), .wdata(queue_a_to_b_wdata),
    .pop(queue_a_to_b_pop), .fill(queue_a_to_b_fill), .head(queue_a_to_b_head));
  bpm_queue_model qba (.aclk, .aresetn, .push(queue_b_to_a_push), .wdata(queue_b_to_a_wdata),
    .pop(queue_b_to_a_pop), .fill(queue_b_to_a_fill), .head(queue_b_to_a_head));
  task automatic report_and_stop();
    $display("Checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  // Timeout
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [35:0] g, e);
    checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %0t: %h not %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [35:0] rnd();
    return 36'({$random(seed), $random(seed)});
  endfunction : rnd
  function automatic logic [35:0] swp(logic [35:0] x, int k);
    return k == 1 ? {x[8:0], x[17:9], x[26:18], x[35:27]} : k == 2 ? {x[17:0], x[35:18]}
      : k == 3 ? {x[26:18], x[35:27], x[8:0], x[17:9]} : x;
  endfunction : swp
  task automatic wr_reg(input logic [31:0] a, d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 0;
    s_axi_wvalid <= 0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
  endtask : wr_reg
  task automatic rd_reg(input logic [31:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask : rd_reg
  task automatic pa_cyc(input logic d, s, mb, input logic [35:0] x);
    port_a_pins <= '{1'b0, d, s, mb, x};
    repeat (5) @(posedge aclk);
    port_a_clock <= 1;
    repeat (5) @(posedge aclk);
    port_a_clock <= 0;
  endtask : pa_cyc
  task automatic pb_cyc(input logic d, s, bpm_width_e z, logic le, int k, logic [35:0] x);
    port_b_pins <= '{1'b0, d, s, z, le, bpm_swap_e'(k), x};
    repeat (5) @(posedge aclk);
    port_b_clock <= 1;
    repeat (5) @(posedge aclk);
    port_b_clock <= 0;
  endtask : pb_cyc
  // Main sequence
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      {offset_select_high_bit, offset_select_low_bit} <= 2'(3 - i);
      aresetn <= 0;
      repeat (20) @(posedge aclk);
      aresetn <= 1;
      repeat (2) @(posedge aclk);
      rd_reg(32'h0000_0000);
      chk(rd[6:0], 7'(16 - 4 * i));
    end
    rd_reg(32'h0000_0010);
    chk(rs, 2'b10);
    w = rnd();
    m = rnd();
    pa_cyc(1, 1, 1, w);
    chk(mailbox_a_to_b_flag_n, 0);
    pa_cyc(1, 1, 1, m);
    rd_reg(32'h0000_0008);
    chk(rd, w[31:0]);
    wr_reg(32'h0000_0004, 32'h0000_0001);
    chk(mailbox_a_to_b_flag_n, 1);
    pb_cyc(0, 1, BPM_MAIL, 0, 1, m);
    chk(port_b_dout, w);
    pb_cyc(1, 1, BPM_MAIL, 0, 0, m);
    rd_reg(32'h0000_000C);
    chk(rd, m[31:0]);
    pa_cyc(0, 1, 1, w);
    chk(port_a_dout, m);
    chk(mailbox_b_to_a_flag_n, 1);
    pb_cyc(0, 0, BPM_LONG, 0, 0, w);
    for (int i = 0; i < 4; i++)
    begin
      exp_q.push_back(rnd());
      pa_cyc(1, 1, 0, exp_q[i]);
    end
    for (int i = 0; i < 4; i++)
    begin
      pb_cyc(0, 1, BPM_LONG, 0, i, w);
      chk(port_b_dout, swp(exp_q.pop_front(), i));
    end
    pb_cyc(1, 0, BPM_WORD, 0, 0, w);
    pb_cyc(1, 1, BPM_WORD, 0, 2, w);
    chk(queue_b_to_a_fill, 0);
    pb_cyc(1, 1, BPM_WORD, 0, 0, {w[17:0], w[35:18]});
    chk(queue_b_to_a_head, swp(w, 2));
    pb_cyc(0, 0, BPM_WORD, 1, 0, w);
    for (int i = 0; i < 16; i++) pa_cyc(1, 1, 0, w);
    chk(port_a_almost_full_n, 1);
    pa_cyc(0, 0, 0, w);
    chk(port_a_almost_full_n, 0);
    pb_cyc(0, 1, BPM_WORD, 1, 0, w);
    chk(port_b_dout[17:0], w[17:0]);
    pa_cyc(0, 0, 0, w);
    chk(port_a_almost_full_n, 0);
    pa_cyc(0, 0, 0, w);
    chk(port_a_almost_full_n, 1);
    report_and_stop();
  end
endmodule : bidir_fifo_portb_match_mailbox_tb_top
